// ==== include/timer0_map.vh ====
`ifndef TIMER0_MAP_VH
`define TIMER0_MAP_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define COUNT_REG_ADDR 8'h01
// ----------------------------------------
// Option fields and reset value
// ----------------------------------------
`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_ASSIGN_BIT 3
`define OPT_RATIO_HI 2
`define OPT_RATIO_LO 0
`define OPT_RESET 8'hFF
// ----------------------------------------
// Timing counts (clk_i phases per cycle; write hold in instruction cycles)
// ----------------------------------------
`define PHASES_PER_CYCLE 4
`define WRITE_HOLD_CYCLES 2'h2
`endif

// ==== src/ripple_prescaler.v ====
`timescale 1ns/1ps
// ----------------------------------------
// Eight-bit prescaler, cleared on request, divided tap selected by ratio
// ----------------------------------------
module ripple_prescaler (
	input wire clk_i,
	input wire resetn_i,
	input wire clear_i,
	input wire tick_i,
	input wire [3:0] tap_i,
	output wire tap_o,
	output wire [7:0] count_o
);
	reg [7:0] cnt_ff;
	reg [7:0] nxt_cnt;
	reg tap_sel;

	// Synchronous stand-in for the ripple chain; bit k is a symmetric divide by 2^(k+1)
	always @* begin
		nxt_cnt = cnt_ff;
		if (tick_i) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
		if (clear_i) begin
			nxt_cnt = 8'h00;
		end
	end

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	always @* begin
		tap_sel = 1'b0;
		if (tap_i < 4'h8) begin
			tap_sel = cnt_ff[tap_i[2:0]];
		end
	end
	assign tap_o = tap_sel;
	assign count_o = cnt_ff;
endmodule

// ==== src/timer0_core.v ====
`timescale 1ns/1ps
`include "timer0_map.vh"
// How it works
// - Source bit clear: count instruction cycles
// - No prescaler: plus one each cycle
// - Count write blocks increments for next two cycle ends
// - Source bit set: count pin edges
// - Edge bit: 0 rising, 1 falling
// - Assign bit: 0 timer, 1 watchdog
// - One prescaler user; other unscaled
// - Timer ratios 1:2 through 1:256
// - Prescaler value not software accessible
// - Eight-bit count register, read/write anytime
// - Unscaled: raw pin goes to synchroniser
// - Sample at second and fourth phases
// - Ripple divider gives symmetric output
// - Increment 9 to 12 phases after pin capture
// - Count write clears timer-owned prescaler
// - Watchdog clear clears watchdog-owned prescaler
// - Reset zeroes prescaler
// - Source bit forces pin to input
module timer0_core (
	input wire clk_i,
	input wire resetn_i,
	input wire ext_count_pin_i,
	input wire reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire option_wr_i,
	input wire [7:0] option_wdata_i,
	input wire watchdog_clear_instr_i,
	input wire watchdog_base_tick_i,
	output reg [7:0] timer_count_value_o,
	output reg [7:0] timer_option_control_o,
	output reg pin_force_input_o,
	output reg watchdog_tick_o,
	output reg instr_cycle_o
);
	// ----------------------------------------
	// Phase generator: four clk_i phases per instruction cycle
	// ----------------------------------------
	reg [1:0] phase_ff;
	wire second_phase;
	wire fourth_phase;
	wire cycle_end;

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			// Phase 0 is the first edge after release
			phase_ff <= 2'h0;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end
	assign second_phase = (phase_ff == 2'h1);
	assign fourth_phase = (phase_ff == 2'h3);
	assign cycle_end = fourth_phase;

	// Low-to-high detector shared by pin, sampler and postscaler paths
	function edge_rise;
		input cur;
		input prev;
		begin
			edge_rise = cur & ~prev;
		end
	endfunction

	// ----------------------------------------
	// Option register
	// ----------------------------------------
	reg [7:0] option_ff;
	wire count_source_select;
	wire source_edge_select;
	wire prescaler_assign;
	wire [2:0] prescale_ratio_field;

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			// Write-only to software; the output copy is for observation
			option_ff <= `OPT_RESET;
		end else if (option_wr_i) begin
			option_ff <= option_wdata_i;
		end
	end
	assign count_source_select = option_ff[`OPT_SRC_BIT];
	assign source_edge_select = option_ff[`OPT_EDGE_BIT];
	assign prescaler_assign = option_ff[`OPT_ASSIGN_BIT];
	assign prescale_ratio_field = option_ff[`OPT_RATIO_HI:`OPT_RATIO_LO];

	// ----------------------------------------
	// Pin synchroniser and edge selection
	// ----------------------------------------
	reg pin_meta_ff;
	reg pin_sync_ff;
	reg pin_prev_ff;
	wire pin_level;
	wire pin_edge;

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
			// Idle pin under the reset option reads high; no false edge
			pin_prev_ff <= 1'b1;
		end else begin
			pin_meta_ff <= ext_count_pin_i;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_level;
		end
	end
	// Inverting for falling edges keeps one rising detector for both
	assign pin_level = pin_sync_ff ^ source_edge_select;
	// Changing the edge bit on a still pin may give one count
	assign pin_edge = edge_rise(pin_level, pin_prev_ff);

	// ----------------------------------------
	// Shared prescaler
	// ----------------------------------------
	wire count_write;
	wire psc_to_timer;
	wire psc_tick;
	wire psc_clear;
	wire psc_tap;
	wire [3:0] psc_tap_sel;
	wire timer_src_tick;

	// Bit set and clear land here too, as full writes
	assign count_write = reg_wr_i && (reg_addr_i == `COUNT_REG_ADDR);
	assign psc_to_timer = ~prescaler_assign;
	// Timer source: instruction cycle or selected pin edge
	assign timer_src_tick = count_source_select ? pin_edge : cycle_end;
	assign psc_tick = psc_to_timer ? timer_src_tick : watchdog_base_tick_i;
	assign psc_clear = (psc_to_timer && count_write) ||
		(!psc_to_timer && watchdog_clear_instr_i);

	// Timer taps bit n (divide 2^(n+1)); watchdog uses n-1, n=0 means no division
	function [3:0] ratio_tap;
		input to_timer;
		input [2:0] field;
		begin
			if (to_timer) begin
				ratio_tap = {1'b0, field};
			end else if (field == 3'h0) begin
				ratio_tap = 4'hF;
			end else begin
				ratio_tap = {1'b0, field - 3'h1};
			end
		end
	endfunction
	assign psc_tap_sel = ratio_tap(psc_to_timer, prescale_ratio_field);

	// Count value stays internal; no register path reaches it
	ripple_prescaler u_psc (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.clear_i(psc_clear),
		.tick_i(psc_tick),
		.tap_i(psc_tap_sel),
		.tap_o(psc_tap),
		.count_o()
	);

	// ----------------------------------------
	// Phase sampling of the timer clock
	// ----------------------------------------
	reg raw_level_ff;
	reg samp_q2_ff;
	reg samp_q4_ff;
	reg samp_prev_ff;
	wire tmr_clk_level;
	reg tmr_inc_event;

	// Raw pin level, or timer-owned prescaler output, forms the timer clock
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			// Starts at the reset-option level so release adds no count
			raw_level_ff <= 1'b1;
		end else begin
			raw_level_ff <= pin_level;
		end
	end
	assign tmr_clk_level = psc_to_timer ? psc_tap : raw_level_ff;

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			// Same start level as the raw pin stage
			samp_q2_ff <= 1'b1;
			samp_q4_ff <= 1'b1;
			samp_prev_ff <= 1'b1;
		end else begin
			if (second_phase) begin
				samp_q2_ff <= tmr_clk_level;
			end
			if (fourth_phase) begin
				samp_q4_ff <= samp_q2_ff;
				samp_prev_ff <= samp_q4_ff;
			end
		end
	end
	// Rising edge seen at a fourth phase; lands 9 to 12 phases after the pin is first clocked in
	always @* begin
		tmr_inc_event = cycle_end;
		if (count_source_select || psc_to_timer) begin
			tmr_inc_event = fourth_phase && edge_rise(samp_q4_ff, samp_prev_ff);
		end
	end

	// ----------------------------------------
	// Count register with write inhibit
	// ----------------------------------------
	reg [7:0] count_ff;
	reg [7:0] nxt_count;
	reg [1:0] hold_ff;
	reg [1:0] nxt_hold;

	always @* begin
		nxt_count = count_ff;
		nxt_hold = hold_ff;
		// Inhibit spans cycle ends, not clocks
		if (cycle_end && hold_ff != 2'h0) begin
			nxt_hold = hold_ff - 2'h1;
		end
		if (count_write) begin
			nxt_count = reg_wdata_i;
			nxt_hold = `WRITE_HOLD_CYCLES;
		end else if (tmr_inc_event && hold_ff == 2'h0) begin
			nxt_count = count_ff + 8'h01;
		end
	end

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			count_ff <= 8'h00;
			hold_ff <= 2'h0;
		end else begin
			count_ff <= nxt_count;
			hold_ff <= nxt_hold;
		end
	end

	// ----------------------------------------
	// Watchdog postscaler
	// ----------------------------------------
	reg wd_tick_seen_ff;
	reg wd_tap_prev_ff;
	reg nxt_wd_tick;

	// Tap edge counts only right after a base tick, so a ratio change cannot fake one
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			wd_tick_seen_ff <= 1'b0;
			wd_tap_prev_ff <= 1'b0;
		end else begin
			wd_tick_seen_ff <= psc_tick;
			wd_tap_prev_ff <= psc_tap;
		end
	end

	// Watchdog is unscaled unless it owns the prescaler with a nonzero ratio field
	always @* begin
		nxt_wd_tick = watchdog_base_tick_i;
		if (!psc_to_timer && psc_tap_sel != 4'hF) begin
			nxt_wd_tick = wd_tick_seen_ff && edge_rise(psc_tap, wd_tap_prev_ff);
		end
	end

	reg [7:0] nxt_option_out;
	reg nxt_force_input;

	// Write data shows at once so the copy never lags the option register
	always @* begin
		nxt_option_out = option_ff;
		nxt_force_input = count_source_select;
		if (option_wr_i) begin
			nxt_option_out = option_wdata_i;
			nxt_force_input = option_wdata_i[`OPT_SRC_BIT];
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			timer_count_value_o <= 8'h00;
			timer_option_control_o <= `OPT_RESET;
			pin_force_input_o <= 1'b1;
			watchdog_tick_o <= 1'b0;
			instr_cycle_o <= 1'b0;
		end else begin
			timer_count_value_o <= nxt_count;
			timer_option_control_o <= nxt_option_out;
			pin_force_input_o <= nxt_force_input;
			watchdog_tick_o <= nxt_wd_tick;
			instr_cycle_o <= cycle_end;
		end
	end
endmodule

// ==== sim/timer0_props.sv ====
`timescale 1ns/1ps
module timer0_props (
	input wire clk_i,
	input wire resetn_i,
	input wire reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire option_wr_i,
	input wire [7:0] option_wdata_i,
	input wire watchdog_base_tick_i,
	input wire [7:0] timer_count_value_o,
	input wire [7:0] timer_option_control_o,
	input wire pin_force_input_o,
	input wire watchdog_tick_o,
	input wire instr_cycle_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_cnt_wr;
		reg_wr_i && reg_addr_i == 8'h01;
	endsequence
	sequence s_quiet;
		!reg_wr_i [*6];
	endsequence
	property p_cnt_wr;
		s_cnt_wr |=> timer_count_value_o == $past(reg_wdata_i);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");
	property p_hold;
		s_cnt_wr ##1 s_quiet |-> timer_count_value_o == $past(timer_count_value_o, 5);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved after write");
	property p_step;
		!$past(reg_wr_i) && timer_count_value_o != $past(timer_count_value_o)
			|-> timer_count_value_o == $past(timer_count_value_o) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count step not one");
	property p_instr;
		instr_cycle_o |=> !instr_cycle_o [*3] ##1 instr_cycle_o;
	endproperty
	a_instr: assert property (p_instr) else $error("cycle not four phases");
	property p_opt_wr;
		option_wr_i |=> timer_option_control_o == $past(option_wdata_i);
	endproperty
	a_opt_wr: assert property (p_opt_wr) else $error("option write lost");
	property p_force;
		option_wr_i ##1 !option_wr_i [*2] |-> pin_force_input_o == timer_option_control_o[5];
	endproperty
	a_force: assert property (p_force) else $error("pin direction wrong");
	property p_wd_direct;
		!timer_option_control_o[3] && watchdog_base_tick_i && !option_wr_i
			|=> ##[0:1] watchdog_tick_o;
	endproperty
	a_wd_direct: assert property (p_wd_direct) else $error("watchdog tick lost");
	property p_wd_origin;
		watchdog_tick_o |-> $past(watchdog_base_tick_i) || $past(watchdog_base_tick_i, 2);
	endproperty
	a_wd_origin: assert property (p_wd_origin) else $error("stray watchdog tick");
	property p_rst;
		disable iff (1'b0) !resetn_i |=> timer_count_value_o == 8'h00
			&& timer_option_control_o == 8'hFF && pin_force_input_o;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

// ==== sim/count_source.sv ====
`timescale 1ns/1ps
module count_source (
	output logic pin_o
);
	// Idles low between bursts
	initial pin_o = 1'b0;
	task automatic burst(input int n);
		repeat (n) begin
			#40 pin_o = 1'b1;
			#40 pin_o = 1'b0;
		end
	endtask
endmodule

// ==== sim/timer0_with_shared_prescaler_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module timer0_with_shared_prescaler_bench;
	logic clk_i, resetn_i, wr, owr, clr, tick, pin, fin, wdt, cyc;
	logic [7:0] adr, wd, od, cnt, opt, c;
	int num_errors = 0;
	int samples_checked = 0;
	int seen = 0;
	typedef struct {logic [7:0] opt; int n; int exp;} row_t;
	row_t rows[3] = '{'{8'h0A, 8, 2}, '{8'h08, 3, 3}, '{8'h00, 3, 3}};
	timer0_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ext_count_pin_i(pin),
		.reg_wr_i(wr), .reg_addr_i(adr), .reg_wdata_i(wd), .option_wr_i(owr),
		.option_wdata_i(od), .watchdog_clear_instr_i(clr), .watchdog_base_tick_i(tick),
		.timer_count_value_o(cnt), .timer_option_control_o(opt),
		.pin_force_input_o(fin), .watchdog_tick_o(wdt), .instr_cycle_o(cyc));
	count_source u_src (.pin_o(pin));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (wdt === 1'b1) seen++;
	// k: 0 count, 1 option, 2 watchdog clear, 3 base tick
	task automatic op(input int k, input logic [7:0] d, input logic [7:0] a = 8'h01);
		@(posedge clk_i);
		{wd, od, adr} <= {d, d, a};
		{wr, owr, clr, tick} <= {k == 0, k == 1, k == 2, k == 3};
		@(posedge clk_i);
		{wr, owr, clr, tick} <= 4'h0;
		@(posedge clk_i);
	endtask
	task automatic ends(input int n);
		repeat (n) begin
			@(posedge clk_i);
			while (cyc !== 1'b1) @(posedge clk_i);
		end
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic finish_test;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		finish_test;
	end
	initial begin
		{resetn_i, wr, owr, clr, tick, wd, od, adr} = {28'h0, 8'h01};
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		`CHK({cnt, opt, fin}, 17'h001FF)
		foreach (rows[i]) begin
			op(2, 8'h00);
			op(0, 8'h00);
			op(1, rows[i].opt);
			op(2, 8'h00);
			seen = 0;
			repeat (rows[i].n) op(3, 8'h00);
			repeat (3) @(posedge clk_i);
			`CHK(seen, rows[i].exp)
		end
		for (int r = 0; r < 8; r++) begin
			op(1, 8'(r));
			ends(3);
			c = cnt;
			ends(4 << r);
			`CHK(cnt, c + 8'h02)
		end
		op(1, 8'h08);
		ends(1);
		c = cnt;
		ends(4);
		`CHK(cnt, c + 8'h04)
		op(0, 8'h40);
		ends(1);
		`CHK(cnt, 8'h40)
		op(0, 8'hFE);
		ends(3);
		c = cnt;
		ends(4);
		`CHK(cnt, c + 8'h04)
		op(1, 8'h28);
		op(0, 8'h10);
		ends(3);
		`CHK({opt, fin}, 9'h051)
		u_src.burst(5);
		ends(3);
		`CHK(cnt, 8'h15)
		op(1, 8'h38);
		ends(4);
		op(0, 8'h15);
		ends(3);
		u_src.burst(5);
		ends(4);
		`CHK(cnt, 8'h1A)
		op(0, 8'h77, 8'h02);
		`CHK(cnt, 8'h1A)
		op(2, 8'h00);
		op(1, 8'h20);
		u_src.burst(4);
		ends(3);
		`CHK(cnt, 8'h1C)
		finish_test;
	end
endmodule
bind timer0_core timer0_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
	.reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.option_wr_i(option_wr_i), .option_wdata_i(option_wdata_i),
	.watchdog_base_tick_i(watchdog_base_tick_i), .timer_count_value_o(timer_count_value_o),
	.timer_option_control_o(timer_option_control_o), .pin_force_input_o(pin_force_input_o),
	.watchdog_tick_o(watchdog_tick_o), .instr_cycle_o(instr_cycle_o));
